// ==== core/fams_pkg.sv ====
package fams_pkg;

    // Operating modes; all but user program are caught from the mode pins at reset release
    typedef enum logic [2:0] {
        FAMS_MODE_USER,
        FAMS_MODE_BOOT,
        FAMS_MODE_USER_PROG,
        FAMS_MODE_USER_BOOT,
        FAMS_MODE_PROGRAMMER
    } fams_mode_e;

    // Mode pin encodings (md pins plus programmer strap)
    localparam logic [2:0] MD_USER       = 3'h3;
    localparam logic [2:0] MD_BOOT       = 3'h1;
    localparam logic [2:0] MD_USER_BOOT  = 3'h2;
    localparam logic [2:0] MD_PROGRAMMER = 3'h4;

    // Array geometry
    localparam logic [17:0] MAIN_LAST_ADDR  = 18'h3FFFF;
    localparam logic [17:0] BOOT_SIZE_BYTES = 18'h02800;
    localparam int          PROG_UNIT_BYTES = 128;
    localparam int          PROG_UNIT_LSB   = 7;
    localparam int          EMU_BLOCK_COUNT = 8;
    localparam logic [17:0] EMU_AREA_END    = 18'h08000;

    // Register byte offsets
    localparam logic [7:0] REG_ARRAY_SEL = 8'h00;
    localparam logic [7:0] REG_STATUS    = 8'h04;
    localparam logic [7:0] REG_PE_CTRL   = 8'h08;
    localparam logic [7:0] REG_PE_ADDR   = 8'h0C;
    localparam logic [7:0] REG_EMU_CTRL  = 8'h10;
    localparam logic [7:0] REG_PROTECT   = 8'h14;

    // Array select key: boot array visible only with this value
    localparam logic [7:0] ARRAY_SEL_BOOT_KEY = 8'hAA;
    localparam logic [7:0] ARRAY_SEL_MAIN     = 8'h00;

    // Software protection key for programming enable
    localparam logic [7:0] PE_KEY = 8'hA5;

    // Field positions of the control/status words
    localparam int PE_CMD_PROG  = 0;
    localparam int PE_CMD_ERASE = 1;
    localparam int PE_TGT_BOOT  = 2;
    localparam int ST_BOOT_VIS  = 0;
    localparam int ST_PE_ALLOW  = 1;
    localparam int ST_ERR_PROT  = 2;
    localparam int ST_REJECT    = 3;
    localparam int ST_MODE_LSB  = 4;
    localparam int ST_VEC_LSB   = 8;

    // Startup vector source states
    typedef enum logic [1:0] {
        FAMS_VEC_EMBEDDED,
        FAMS_VEC_MAIN,
        FAMS_VEC_BOOT
    } fams_vec_e;

endpackage

// ==== core/fams_wb_slave.sv ====
`timescale 1ns/1ps
`default_nettype none
// Classic Wishbone slave front: one-cycle ack pulse per access
module fams_wb_slave (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    input  wire logic [31:0] rd_data_i,
    output logic             ack_o,
    output logic             wr_stb_o,
    output logic [7:0]       wr_adr_o,
    output logic [3:0]       wr_sel_o,
    output logic [31:0]      wr_dat_o,
    output logic [31:0]      dat_o
);
    typedef struct packed {
        logic        ack;
        logic        wr_stb;
        logic [7:0]  wr_adr;
        logic [3:0]  wr_sel;
        logic [31:0] wr_dat;
        logic [31:0] dat;
    } fams_wb_s;

    fams_wb_s st;
    fams_wb_s next_st;

    // Answer one cycle after the request; gap prevents double take
    always_comb begin
        next_st        = st;
        next_st.wr_stb = 1'b0;
        next_st.ack    = 1'b0;
        if (cyc_i && stb_i && !st.ack) begin
            next_st.ack    = 1'b1;
            next_st.wr_stb = we_i;
            next_st.wr_adr = adr_i;
            next_st.wr_sel = sel_i;
            next_st.wr_dat = dat_i;
            next_st.dat    = we_i ? 32'h0000_0000 : rd_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign ack_o    = st.ack;
    assign wr_stb_o = st.wr_stb;
    assign wr_adr_o = st.wr_adr;
    assign wr_sel_o = st.wr_sel;
    assign wr_dat_o = st.wr_dat;
    assign dat_o    = st.dat;
endmodule
`default_nettype wire

// ==== core/fams_top.sv ====
// Implementation choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Both arrays share one start address
// - Latched mode picks first visible array
// - Software bank-switches visible array
// - Normal user mode starts main array
// - User boot mode starts boot array
// - Normal user mode blocks program/erase
// - Program/erase only in four flash modes
// - Mode pins sampled in reset, applied after
// - Boot mode programs both arrays via serial
// - User boot mode programs main array only
// - Programmer mode programs both arrays
// - Reset start source follows the mode
// - Program data via RAM or serial
// - RAM overlay only user program/boot modes
// - Programming writes 128-byte units
// - Hardware, software and error protection
// - Boot array writable only boot/programmer
// - Reads beyond boot array are undefined
// - User boot vector: embedded then array
module fams_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [2:0]  mode_pins_i,
    input  wire logic        prog_enter_i,
    input  wire logic        prog_done_i,
    input  wire logic        hw_protect_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [17:0] fetch_addr_i,
    input  wire logic        vec_checked_i,
    output logic             wb_ack_o,
    output logic [31:0]      wb_dat_o,
    output logic             boot_visible_o,
    output logic [17:0]      array_addr_o,
    output logic             read_undef_o,
    output logic [1:0]       vec_source_o,
    output logic             serial_boot_en_o,
    output logic             emu_overlay_o,
    output logic             pe_strobe_o,
    output logic             pe_erase_o,
    output logic             pe_target_boot_o,
    output logic [17:0]      pe_addr_o
);
    typedef struct packed {
        logic [2:0]            pin_s1;
        logic [2:0]            pin_s2;
        logic [2:0]            pin_s3;
        logic [2:0]            pin_stable;
        logic                  pe_s1;
        logic                  pe_s2;
        logic                  pe_s3;
        logic                  pe_lvl;
        logic                  pd_s1;
        logic                  pd_s2;
        logic                  pd_s3;
        logic                  pd_lvl;
        logic                  hp_s1;
        logic                  hp_s2;
        logic                  hp_s3;
        logic                  hp_lvl;
        logic                  vc_s1;
        logic                  vc_s2;
        logic                  vc_s3;
        logic                  vc_lvl;
        logic                  in_reset;
        fams_pkg::fams_mode_e  mode;
        logic [7:0]            array_sel;
        fams_pkg::fams_vec_e   vec;
        logic [7:0]            pe_key;
        logic [17:0]           pe_addr;
        logic [7:0]            emu_ctrl;
        logic                  err_prot;
        logic                  reject;
        logic                  pe_strobe;
        logic                  pe_erase;
        logic                  pe_tgt_boot;
        logic                  boot_vis;
        logic [17:0]           arr_addr;
        logic                  undef;
        logic                  serial_en;
        logic                  emu_ov;
    } fams_state_s;

    fams_state_s st;
    fams_state_s next_st;

    logic        wr_stb;
    logic [7:0]  wr_adr;
    logic [3:0]  wr_sel;
    logic [31:0] wr_dat;
    logic [31:0] rd_data;

    // Decode a pin code into a mode; unknown codes fall back to user mode
    function automatic fams_pkg::fams_mode_e decode_mode(input logic [2:0] pins);
        fams_pkg::fams_mode_e m;
        m = fams_pkg::FAMS_MODE_USER;
        if (pins == fams_pkg::MD_BOOT) begin
            m = fams_pkg::FAMS_MODE_BOOT;
        end else if (pins == fams_pkg::MD_USER_BOOT) begin
            m = fams_pkg::FAMS_MODE_USER_BOOT;
        end else if (pins == fams_pkg::MD_PROGRAMMER) begin
            m = fams_pkg::FAMS_MODE_PROGRAMMER;
        end
        return m;
    endfunction

    // Is a program/erase of the given array allowed in this mode
    function automatic logic pe_allowed(input fams_pkg::fams_mode_e m, input logic boot_tgt);
        logic ok;
        ok = 1'b0;
        unique case (m)
            fams_pkg::FAMS_MODE_BOOT:       ok = 1'b1;
            fams_pkg::FAMS_MODE_PROGRAMMER: ok = 1'b1;
            fams_pkg::FAMS_MODE_USER_PROG:  ok = !boot_tgt;
            fams_pkg::FAMS_MODE_USER_BOOT:  ok = !boot_tgt;
            fams_pkg::FAMS_MODE_USER:       ok = 1'b0;
        endcase
        return ok;
    endfunction

    // Two-flop-agree filter on a synchronised pin
    function automatic logic settle(input logic s2, input logic s3, input logic cur);
        return (s2 == s3) ? s3 : cur;
    endfunction

    fams_wb_slave u_wb (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .cyc_i     (wb_cyc_i),
        .stb_i     (wb_stb_i),
        .we_i      (wb_we_i),
        .adr_i     (wb_adr_i),
        .sel_i     (wb_sel_i),
        .dat_i     (wb_dat_i),
        .rd_data_i (rd_data),
        .ack_o     (wb_ack_o),
        .wr_stb_o  (wr_stb),
        .wr_adr_o  (wr_adr),
        .wr_sel_o  (wr_sel),
        .wr_dat_o  (wr_dat),
        .dat_o     (wb_dat_o)
    );

    // Register read mux; unmapped offsets read zero
    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (wb_adr_i)
            fams_pkg::REG_ARRAY_SEL: rd_data[7:0] = st.array_sel;
            fams_pkg::REG_STATUS: begin
                rd_data[fams_pkg::ST_BOOT_VIS] = st.boot_vis;
                rd_data[fams_pkg::ST_PE_ALLOW] = pe_allowed(st.mode, 1'b0)
                                                 && st.pe_key == fams_pkg::PE_KEY;
                rd_data[fams_pkg::ST_ERR_PROT] = st.err_prot;
                rd_data[fams_pkg::ST_REJECT]   = st.reject;
                rd_data[fams_pkg::ST_MODE_LSB +: 3] = st.mode;
                rd_data[fams_pkg::ST_VEC_LSB +: 2]  = st.vec;
            end
            fams_pkg::REG_PE_CTRL:  rd_data[7:0]  = st.pe_key;
            fams_pkg::REG_PE_ADDR:  rd_data[17:0] = st.pe_addr;
            fams_pkg::REG_EMU_CTRL: rd_data[7:0]  = st.emu_ctrl;
            default:                rd_data = 32'h0000_0000;
        endcase
    end

    // Next-state logic for mode capture, selection and protection
    always_comb begin
        logic      is_boot_sel;
        logic      tgt_boot;
        logic      cmd_prog;
        logic      cmd_erase;
        logic      emu_ok;
        next_st = st;
        is_boot_sel = 1'b0;
        tgt_boot = 1'b0;
        cmd_prog = 1'b0;
        cmd_erase = 1'b0;
        emu_ok = 1'b0;

        // Pin synchronisers; only s2 vs s3 agreement is looked at
        next_st.pin_s1 = mode_pins_i;
        next_st.pin_s2 = st.pin_s1;
        next_st.pin_s3 = st.pin_s2;
        if (st.pin_s2 == st.pin_s3) begin
            next_st.pin_stable = st.pin_s3;
        end
        next_st.pe_s1 = prog_enter_i;
        next_st.pe_s2 = st.pe_s1;
        next_st.pe_s3 = st.pe_s2;
        next_st.pe_lvl = settle(st.pe_s2, st.pe_s3, st.pe_lvl);
        next_st.pd_s1 = prog_done_i;
        next_st.pd_s2 = st.pd_s1;
        next_st.pd_s3 = st.pd_s2;
        next_st.pd_lvl = settle(st.pd_s2, st.pd_s3, st.pd_lvl);
        next_st.hp_s1 = hw_protect_i;
        next_st.hp_s2 = st.hp_s1;
        next_st.hp_s3 = st.hp_s2;
        next_st.hp_lvl = settle(st.hp_s2, st.hp_s3, st.hp_lvl);
        next_st.vc_s1 = vec_checked_i;
        next_st.vc_s2 = st.vc_s1;
        next_st.vc_s3 = st.vc_s2;
        next_st.vc_lvl = settle(st.vc_s2, st.vc_s3, st.vc_lvl);

        next_st.in_reset = 1'b0;
        next_st.pe_strobe = 1'b0;

        if (st.in_reset) begin
            // First cycle after release: enter mode from sampled pins
            next_st.mode = decode_mode(st.pin_stable);
            unique case (decode_mode(st.pin_stable))
                fams_pkg::FAMS_MODE_USER_BOOT: begin
                    next_st.array_sel = fams_pkg::ARRAY_SEL_BOOT_KEY;
                    next_st.vec = fams_pkg::FAMS_VEC_EMBEDDED;
                end
                fams_pkg::FAMS_MODE_BOOT: begin
                    next_st.array_sel = fams_pkg::ARRAY_SEL_MAIN;
                    next_st.vec = fams_pkg::FAMS_VEC_EMBEDDED;
                end
                default: begin
                    next_st.array_sel = fams_pkg::ARRAY_SEL_MAIN;
                    next_st.vec = fams_pkg::FAMS_VEC_MAIN;
                end
            endcase
        end else begin
            // User boot start: refetch vector once registers are checked
            if (st.vec == fams_pkg::FAMS_VEC_EMBEDDED && st.vc_lvl
                && st.mode == fams_pkg::FAMS_MODE_USER_BOOT) begin
                next_st.vec = fams_pkg::FAMS_VEC_BOOT;
            end
            // User program mode lives from entry until its procedure ends
            if (st.mode == fams_pkg::FAMS_MODE_USER && st.pe_lvl) begin
                next_st.mode = fams_pkg::FAMS_MODE_USER_PROG;
            end else if (st.mode == fams_pkg::FAMS_MODE_USER_PROG && st.pd_lvl) begin
                next_st.mode = fams_pkg::FAMS_MODE_USER;
                next_st.pe_key = 8'h00;
            end

            if (wr_stb) begin
                unique case (wr_adr)
                    fams_pkg::REG_ARRAY_SEL: begin
                        if (wr_sel[0]) begin
                            next_st.array_sel = wr_dat[7:0];
                        end
                    end
                    fams_pkg::REG_PE_CTRL: begin
                        if (wr_sel[0]) begin
                            next_st.pe_key = wr_dat[7:0];
                        end
                    end
                    fams_pkg::REG_PE_ADDR: begin
                        // Low bits dropped: units start on 128-byte lines
                        next_st.pe_addr = {wr_dat[17:fams_pkg::PROG_UNIT_LSB],
                                           7'h00};
                    end
                    fams_pkg::REG_EMU_CTRL: begin
                        if (wr_sel[0]) begin
                            next_st.emu_ctrl = wr_dat[7:0];
                        end
                    end
                    fams_pkg::REG_PROTECT: begin
                        // Software clears error lock; a new error wins below
                        next_st.err_prot = 1'b0;
                        next_st.reject = 1'b0;
                    end
                    fams_pkg::REG_STATUS: begin
                        cmd_prog  = wr_dat[fams_pkg::PE_CMD_PROG];
                        cmd_erase = wr_dat[fams_pkg::PE_CMD_ERASE];
                        tgt_boot  = wr_dat[fams_pkg::PE_TGT_BOOT];
                    end
                    default: begin
                    end
                endcase
            end

            // Program/erase launch through three protection layers
            if (cmd_prog || cmd_erase) begin
                if (pe_allowed(st.mode, tgt_boot) && !st.hp_lvl
                    && st.pe_key == fams_pkg::PE_KEY && !st.err_prot
                    && !(cmd_prog && cmd_erase)) begin
                    next_st.pe_strobe   = 1'b1;
                    next_st.pe_erase    = cmd_erase;
                    next_st.pe_tgt_boot = tgt_boot;
                end else begin
                    next_st.reject = 1'b1;
                    if (cmd_prog && cmd_erase) begin
                        next_st.err_prot = 1'b1;
                    end
                end
            end
        end

        // Visible array: one of the two answers the shared window
        is_boot_sel = next_st.array_sel == fams_pkg::ARRAY_SEL_BOOT_KEY;
        next_st.boot_vis = is_boot_sel;
        next_st.arr_addr = fetch_addr_i & fams_pkg::MAIN_LAST_ADDR;
        next_st.undef = is_boot_sel && fetch_addr_i >= fams_pkg::BOOT_SIZE_BYTES;
        next_st.serial_en = next_st.mode == fams_pkg::FAMS_MODE_BOOT;
        emu_ok = next_st.mode == fams_pkg::FAMS_MODE_USER_PROG
                 || next_st.mode == fams_pkg::FAMS_MODE_USER_BOOT;
        next_st.emu_ov = emu_ok && next_st.emu_ctrl[0]
                         && fetch_addr_i < fams_pkg::EMU_AREA_END
                         && !is_boot_sel;
    end

    // Reset holds in_reset high so pins are caught at release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st          <= '0;
            st.in_reset <= 1'b1;
            st.mode     <= fams_pkg::FAMS_MODE_USER;
            st.vec      <= fams_pkg::FAMS_VEC_MAIN;
            st.pin_s1   <= next_st.pin_s1;
            st.pin_s2   <= next_st.pin_s2;
            st.pin_s3   <= next_st.pin_s3;
            st.pin_stable <= next_st.pin_stable;
        end else begin
            st <= next_st;
        end
    end

    assign boot_visible_o   = st.boot_vis;
    assign array_addr_o     = st.arr_addr;
    assign read_undef_o     = st.undef;
    assign vec_source_o     = st.vec;
    assign serial_boot_en_o = st.serial_en;
    assign emu_overlay_o    = st.emu_ov;
    assign pe_strobe_o      = st.pe_strobe;
    assign pe_erase_o       = st.pe_erase;
    assign pe_target_boot_o = st.pe_tgt_boot;
    assign pe_addr_o        = st.pe_addr;
endmodule
`default_nettype wire

// ==== test/fams_top_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// Watches mode, bank and program/erase ports
module fams_top_props (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        hw_protect_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [17:0] fetch_addr_i,
    input wire logic        boot_visible_o,
    input wire logic [17:0] array_addr_o,
    input wire logic        read_undef_o,
    input wire logic [1:0]  vec_source_o,
    input wire logic        serial_boot_en_o,
    input wire logic        emu_overlay_o,
    input wire logic        pe_strobe_o,
    input wire logic        pe_target_boot_o,
    input wire logic [17:0] pe_addr_o
);
    // Single domain, so clock and reset are given once
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_ack_resp;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
    // Guarded so the edge after release does not look at reset values
    property p_addr_echo;
        !$past(rst_i) |-> array_addr_o == $past(fetch_addr_i);
    endproperty
    a_addr_echo: assert property (p_addr_echo) else $error("window address lost");
    property p_undef;
        read_undef_o |-> array_addr_o >= fams_pkg::BOOT_SIZE_BYTES
            && (boot_visible_o || $past(boot_visible_o));
    endproperty
    a_undef: assert property (p_undef) else $error("undefined flag wrong");
    property p_pe_align;
        pe_strobe_o |-> pe_addr_o[6:0] == 7'h00;
    endproperty
    a_pe_align: assert property (p_pe_align) else $error("unaligned unit");
    property p_pe_pulse;
        pe_strobe_o |=> !pe_strobe_o;
    endproperty
    a_pe_pulse: assert property (p_pe_pulse) else $error("strobe held");
    // Six cycles cover the input synchroniser
    property p_hw;
        hw_protect_i [*6] |=> !pe_strobe_o;
    endproperty
    a_hw: assert property (p_hw) else $error("strobe under hw lock");
    property p_emu;
        emu_overlay_o |-> !serial_boot_en_o && array_addr_o < fams_pkg::EMU_AREA_END;
    endproperty
    a_emu: assert property (p_emu) else $error("overlay out of place");
    property p_vec;
        $past(vec_source_o) == 2'h0 && vec_source_o != 2'h0
            |-> vec_source_o == 2'h2 && !serial_boot_en_o;
    endproperty
    a_vec: assert property (p_vec) else $error("bad vector move");
    property p_serial_vec;
        serial_boot_en_o |-> vec_source_o == 2'h0;
    endproperty
    a_serial_vec: assert property (p_serial_vec) else $error("boot vector wrong");
    c_pe_boot: cover property (pe_strobe_o && pe_target_boot_o);
    c_undef: cover property (read_undef_o);
    c_emu: cover property (emu_overlay_o);
endmodule
bind fams_top fams_top_props fams_top_props_i (.clk_i, .rst_i, .hw_protect_i, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .fetch_addr_i, .boot_visible_o, .array_addr_o, .read_undef_o,
    .vec_source_o, .serial_boot_en_o, .emu_overlay_o, .pe_strobe_o, .pe_target_boot_o,
    .pe_addr_o);
`default_nettype wire

// ==== test/fams_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Processor core: walks the shared window, reports register check
module fams_cpu_model #(
    parameter int CHECK_DLY = 60
) (
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    output logic [17:0] fetch_addr_o,
    output logic        vec_checked_o
);
    int cnt;
    // Even 0x1A40 stride so fetches land in overlay and hole zones
    always @(posedge clk_i) begin
        if (rst_i) begin
            fetch_addr_o <= 18'h00000;
            vec_checked_o <= 1'b0;
            cnt <= 0;
        end else begin
            fetch_addr_o <= fetch_addr_o + 18'h01A40;
            if (cnt < CHECK_DLY) cnt <= cnt + 1;
            vec_checked_o <= (cnt == CHECK_DLY); // Stays high once reached
        end
    end
endmodule
`default_nettype wire

// ==== test/test_fams_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_fams_top;
    typedef struct {string nm; logic [31:0] m; logic [31:0] v;} fams_tb_note_s;
    localparam logic [2:0] PV [4] = '{fams_pkg::MD_USER, fams_pkg::MD_BOOT,
        fams_pkg::MD_USER_BOOT, fams_pkg::MD_PROGRAMMER};
    localparam fams_pkg::fams_mode_e MD [4] = '{fams_pkg::FAMS_MODE_USER,
        fams_pkg::FAMS_MODE_BOOT, fams_pkg::FAMS_MODE_USER_BOOT, fams_pkg::FAMS_MODE_PROGRAMMER};
    localparam logic [1:0] V0 [4] = '{2'h1, 2'h0, 2'h0, 2'h1};
    localparam logic [1:0] V1 [4] = '{2'h1, 2'h0, 2'h2, 2'h1};
    localparam logic [31:0] MK [4] = '{32'h371, 32'h371, 32'h371, 32'h371};
    localparam logic [3:0] OKM = 4'hE; // Main array writable, per mode
    localparam logic [3:0] OKB = 4'hA; // Boot array writable, per mode
    logic clk_i = 1'b0, rst_i = 1'b1, enter = 1'b0, done = 1'b0, hw = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [2:0] pins = 3'h3;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, rs = 32'h0000459E;
    logic [17:0] faddr, aaddr, pea;
    logic [1:0] vec;
    logic chkd, ack, bvis, undef, sen, emu, pes, pee, pet;
    int n_mismatch = 0, samples_checked = 0, cycles = 0, k;
    fams_tb_note_s rq[$], pq[$], e;

    always #2.5 clk_i = ~clk_i;

    fams_top fams_top_i (.clk_i, .rst_i, .mode_pins_i(pins), .prog_enter_i(enter),
        .prog_done_i(done), .hw_protect_i(hw), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .fetch_addr_i(faddr),
        .vec_checked_i(chkd), .wb_ack_o(ack), .wb_dat_o(rdat), .boot_visible_o(bvis),
        .array_addr_o(aaddr), .read_undef_o(undef), .vec_source_o(vec),
        .serial_boot_en_o(sen), .emu_overlay_o(emu), .pe_strobe_o(pes),
        .pe_erase_o(pee), .pe_target_boot_o(pet), .pe_addr_o(pea));
    fams_cpu_model #(.CHECK_DLY(60)) fams_cpu_model_i (.clk_i, .rst_i,
        .fetch_addr_o(faddr), .vec_checked_o(chkd));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Classic single cycle; ack read at the edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) chk("ack", 32'h0, 32'h1);
        {cyc, stb} <= 2'b00;
        @(posedge clk_i);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] v);
        rq.push_back('{nm, m, v & m});
        wb(1'b0, a, 32'h0);
    endtask
    // Key, address, command; accepted ones leave a note
    task automatic pe(input logic [2:0] cmd, input logic ok);
        rs = xs(rs);
        wb(1'b1, fams_pkg::REG_PE_CTRL, {24'h0, fams_pkg::PE_KEY});
        wb(1'b1, fams_pkg::REG_PE_ADDR, {14'h0, rs[17:0]});
        if (ok) pq.push_back('{"pe", 32'hFFFFFFFF, {12'h0, cmd[1], cmd[2], rs[17:7], 7'h0}});
        wb(1'b1, fams_pkg::REG_STATUS, {29'h0, cmd});
        repeat (4) @(posedge clk_i);
    endtask
    task automatic rst_mode(input logic [2:0] p);
        {pins, rst_i} <= {p, 1'b1};
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    // Each read ack or strobe takes the oldest note
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (ack === 1'b1 && we === 1'b0) begin
            e = rq.size() ? rq.pop_front() : '{"read note", 32'h0, 32'h1};
            chk(e.nm, rdat & e.m, e.v);
        end
        if (pes === 1'b1) begin
            e = pq.size() ? pq.pop_front() : '{"pe note", 32'h1, 32'h1};
            chk(e.nm, {12'h0, pee, pet, pea}, e.v);
        end
        if (cycles > 8000) begin
            n_mismatch++;
            summarize();
        end
    end

    initial begin
        @(posedge clk_i);
        for (int i = 0; i < 4; i++) begin
            rst_mode(PV[i]);
            rd("mode", fams_pkg::REG_STATUS, MK[i], {22'h0, V0[i], 1'b0, MD[i], 3'h0, i == 2});
            chk("serial", {31'h0, sen}, {31'h0, i == 1});
            pe(3'b001, OKM[i]);
            pe(3'b110, OKB[i]);
            repeat (70) @(posedge clk_i);
            rd("vec", fams_pkg::REG_STATUS, MK[i] & 32'h300, {22'h0, V1[i], 8'h0});
            chk("vsrc", {30'h0, vec}, {30'h0, V1[i]});
            $display("test mode %0d done", i);
        end
        // Late pin moves must not change the mode
        rst_mode(fams_pkg::MD_USER);
        pins <= fams_pkg::MD_BOOT;
        pe(3'b010, 1'b0);
        rd("reject", fams_pkg::REG_STATUS, 32'h079, 32'h008);
        wb(1'b1, fams_pkg::REG_PROTECT, 32'h0);
        rd("clear", fams_pkg::REG_STATUS, 32'h008, 32'h0);
        wb(1'b1, fams_pkg::REG_ARRAY_SEL, {24'h0, fams_pkg::ARRAY_SEL_BOOT_KEY});
        rd("bank", fams_pkg::REG_STATUS, 32'h1, 32'h1);
        @(posedge clk_i);
        chk("bvis", {31'h0, bvis}, 32'h1);
        repeat (40) @(posedge clk_i);
        wb(1'b1, fams_pkg::REG_ARRAY_SEL, {24'h0, fams_pkg::ARRAY_SEL_MAIN});
        rd("main", fams_pkg::REG_STATUS, 32'h1, 32'h0);
        rd("hole", 8'h20, 32'hFFFFFFFF, 32'h0);
        $display("test user done");
        enter <= 1'b1;
        repeat (8) @(posedge clk_i);
        rd("uprog", fams_pkg::REG_STATUS, 32'h070, 32'h020);
        wb(1'b1, fams_pkg::REG_EMU_CTRL, 32'h1);
        k = 0;
        while (emu !== 1'b1 && k < 100) begin
            @(posedge clk_i);
            k++;
        end
        chk("emu", {31'h0, emu}, 32'h1);
        pe(3'b001, 1'b1);
        pe(3'b101, 1'b0);
        {enter, done} <= 2'b01;
        repeat (8) @(posedge clk_i);
        done <= 1'b0;
        rd("uend", fams_pkg::REG_STATUS, 32'h070, 32'h0);
        pe(3'b001, 1'b0);
        $display("test user program done");
        rst_mode(fams_pkg::MD_PROGRAMMER);
        hw <= 1'b1;
        repeat (6) @(posedge clk_i);
        pe(3'b001, 1'b0);
        hw <= 1'b0;
        repeat (6) @(posedge clk_i);
        pe(3'b011, 1'b0);
        rd("lock", fams_pkg::REG_STATUS, 32'h4, 32'h4);
        pe(3'b001, 1'b0);
        wb(1'b1, fams_pkg::REG_PROTECT, 32'h0);
        pe(3'b101, 1'b1);
        repeat (10) @(posedge clk_i);
        chk("pe left", pq.size(), 32'h0);
        $display("test protection done");
        summarize();
    end
endmodule
`default_nettype wire
